// ===== src/ocs_clock_select.sv
// Purpose: Power-on source selection, clock dividers and PLL ratio status
// Assumes: Configuration word and oscillator clocks arrive asynchronously
// Notes:   Oscillator inputs are sampled at core_clk; dividers act on edges
//Contract
// - Instruction clock is oscillator output halved
// - RC postscale from three-bit field
// - Power-on source from config fields
// - Source codes map to eight sources
// - Primary mode selects fast crystal, crystal, external
// - Erased config starts RC divide-n
// - PLL prescale 2 to 33
// - VCO multiplies by feedback factor
// - Postscale by 2, 4 or 8
// - Output is input times feedback over dividers
// - Only RC and primary feed PLL
// - Low-power RC clocks watchdog and monitor
// - Fast RC 7.37 MHz, software tunable
// - Auxiliary oscillator with three modes
// - Prescale code plus two, default 2
// - Feedback code plus two, default 50
// - Postscale codes 2,4,reserved,8; default 4
// - RC postscale 1..64 then 256
module ocs_clock_select (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        config_erased,
    input  wire logic [2:0]  initial_source_select,
    input  wire logic [1:0]  primary_mode_select,
    input  wire logic        fast_internal_rc,
    input  wire logic        low_power_internal_rc,
    input  wire logic        primary_osc_input,
    input  wire logic        secondary_osc_input,
    input  wire logic        pll_clock,
    input  wire logic        pll_locked,
    input  wire logic        auxiliary_oscillator,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             fosc_tick,
    output logic             fcy_tick,
    output logic             sys_clk_active,
    output logic             pll_input_clock,
    output logic             ref_clock_tick,
    output logic      [5:0]  rc_tune,
    output logic      [9:0]  multiplier,
    output logic      [5:0]  prescale_factor,
    output logic      [3:0]  postscale_factor,
    output logic      [1:0]  primary_drive
);
    // Two-flop synchronisers for all asynchronous inputs
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] s1_r;
    logic [NSYNC-1:0] s2_r;
    logic [NSYNC-1:0] s3_r;
    always_ff @(posedge core_clk) begin
        s1_r <= {pll_locked, auxiliary_oscillator, pll_clock, secondary_osc_input,
                 primary_osc_input, low_power_internal_rc, fast_internal_rc};
        s2_r <= s1_r;
        s3_r <= s2_r;
    end
    logic [NSYNC-1:0] rise;
    assign rise = s2_r & ~s3_r;

    // Config fields are static straps but still synchronised
    logic [5:0] cfg1_r;
    logic [5:0] cfg2_r;
    always_ff @(posedge core_clk) begin
        cfg1_r <= {config_erased, primary_mode_select, initial_source_select};
        cfg2_r <= cfg1_r;
    end

    // RC postscale divide ratio from code
    function automatic logic [8:0] rc_ratio(input logic [2:0] code);
        rc_ratio = (code == 3'h7) ? 9'h100 : 9'(9'h001 << code);
    endfunction : rc_ratio

    // Software registers and power-on state
    logic [2:0]  src_r,   src_nxt;
    logic [1:0]  pmode_r, pmode_nxt;
    logic [2:0]  rcdiv_r, rcdiv_nxt;
    logic [1:0]  post_r,  post_nxt;
    logic [4:0]  pre_r,   pre_nxt;
    logic [8:0]  fbd_r,   fbd_nxt;
    logic [5:0]  tune_r,  tune_nxt;
    logic [1:0]  aux_r,   aux_nxt;
    logic [31:0] rd_r,    rd_nxt;
    logic        err_r,   err_nxt;
    logic [15:0] cnt_r,   cnt_nxt;
    ocs_pkg::ocs_state_t st_r, st_nxt;

    logic acc;
    logic wr;
    logic needs_lock;
    logic src_rise;
    assign acc = psel & penable;
    // Writes land only on the ready edge; the wait cycle decodes errors
    assign wr  = pready & pwrite;
    assign needs_lock = (src_r == ocs_pkg::SRC_RC_PLL) || (src_r == ocs_pkg::SRC_PRI_PLL);

    // Selected source edge; secondary and low-power RC bypass the PLL
    always_comb begin
        case (ocs_pkg::ocs_src_t'(src_r))
            ocs_pkg::SRC_RC,
            ocs_pkg::SRC_RC_D16,
            ocs_pkg::SRC_RC_DIVN: src_rise = rise[0];
            ocs_pkg::SRC_PRI:     src_rise = rise[2];
            ocs_pkg::SRC_SEC:     src_rise = rise[3];
            ocs_pkg::SRC_LOWRC:   src_rise = rise[1];
            ocs_pkg::SRC_RC_PLL,
            ocs_pkg::SRC_PRI_PLL: src_rise = rise[4];
            default:              src_rise = 1'b0;
        endcase
    end

    // Registers, start-up state and APB read mux
    always_comb begin
        src_nxt   = src_r;
        pmode_nxt = pmode_r;
        rcdiv_nxt = rcdiv_r;
        post_nxt  = post_r;
        pre_nxt   = pre_r;
        fbd_nxt   = fbd_r;
        tune_nxt  = tune_r;
        aux_nxt   = aux_r;
        rd_nxt    = rd_r;
        err_nxt   = 1'b0;
        st_nxt    = st_r;
        cnt_nxt   = cnt_r;
        case (st_r)
            ocs_pkg::ST_LOAD: begin
                // Config reloaded each power-on, erased means RC divide-n
                src_nxt   = cfg2_r[5] ? ocs_pkg::SRC_ERASED : cfg2_r[2:0];
                pmode_nxt = cfg2_r[5] ? ocs_pkg::MODE_ERASED : cfg2_r[4:3];
                cnt_nxt   = 16'h0000;
                st_nxt    = ocs_pkg::ST_WAIT;
            end
            ocs_pkg::ST_WAIT: begin
                // Count source edges; PLL modes also need lock
                if (src_rise && cnt_r != 16'(ocs_pkg::STARTUP_CYC))
                    cnt_nxt = cnt_r + 16'h0001;
                if (cnt_r == 16'(ocs_pkg::STARTUP_CYC) && (!needs_lock || s2_r[6]))
                    st_nxt = ocs_pkg::ST_RUN;
            end
            ocs_pkg::ST_RUN: st_nxt = ocs_pkg::ST_RUN;
            default:         st_nxt = ocs_pkg::ST_LOAD;
        endcase
        if (wr) begin
            case (paddr)
                ocs_pkg::DIV_OFF: begin
                    rcdiv_nxt = pwdata[ocs_pkg::RCDIV_LSB +: 3];
                    post_nxt  = pwdata[ocs_pkg::POST_LSB +: 2];
                    pre_nxt   = pwdata[ocs_pkg::PRE_LSB +: 5];
                end
                ocs_pkg::FBD_OFF:  fbd_nxt  = pwdata[8:0];
                ocs_pkg::TUNE_OFF: tune_nxt = pwdata[5:0];
                ocs_pkg::AUX_OFF:  aux_nxt  = pwdata[1:0];
                ocs_pkg::CFG_OFF,
                ocs_pkg::STAT_OFF: err_nxt  = 1'b0;
                default:           err_nxt  = 1'b1;
            endcase
        end else if (acc) begin
            case (paddr)
                ocs_pkg::CFG_OFF:  rd_nxt = {27'h0, pmode_r, src_r};
                ocs_pkg::DIV_OFF:  rd_nxt = {21'h0, rcdiv_r, post_r, 1'b0, pre_r};
                ocs_pkg::FBD_OFF:  rd_nxt = {23'h0, fbd_r};
                ocs_pkg::TUNE_OFF: rd_nxt = {26'h0, tune_r};
                ocs_pkg::STAT_OFF: rd_nxt = {29'h0, s2_r[6], st_r};
                ocs_pkg::AUX_OFF:  rd_nxt = {30'h0, aux_r};
                default: begin
                    rd_nxt  = 32'h0000_0000;
                    err_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            src_r   <= ocs_pkg::SRC_ERASED;
            pmode_r <= ocs_pkg::MODE_ERASED;
            rcdiv_r <= ocs_pkg::RCDIV_RST;
            post_r  <= ocs_pkg::POST_RST;
            pre_r   <= ocs_pkg::PRE_RST;
            fbd_r   <= ocs_pkg::FBD_RST;
            tune_r  <= ocs_pkg::TUNE_RST;
            aux_r   <= ocs_pkg::AUX_RST;
            rd_r    <= 32'h0000_0000;
            err_r   <= 1'b0;
            cnt_r   <= 16'h0000;
            st_r    <= ocs_pkg::ST_LOAD;
        end else begin
            src_r   <= src_nxt;
            pmode_r <= pmode_nxt;
            rcdiv_r <= rcdiv_nxt;
            post_r  <= post_nxt;
            pre_r   <= pre_nxt;
            fbd_r   <= fbd_nxt;
            tune_r  <= tune_nxt;
            aux_r   <= aux_nxt;
            rd_r    <= rd_nxt;
            err_r   <= err_nxt;
            cnt_r   <= cnt_nxt;
            st_r    <= st_nxt;
        end
    end

    // Read data and error registered in the first access cycle
    logic setup_hold_r;
    always_ff @(posedge core_clk) begin
        if (sys_rst)
            setup_hold_r <= 1'b0;
        else
            setup_hold_r <= psel & ~penable;
    end
    // One wait state so registered read data is ready
    assign pready  = acc & ~setup_hold_r;
    assign prdata  = rd_r;
    assign pslverr = err_r & pready;

    // Oscillator output: RC divide modes, else selected source edge
    logic [8:0] div_cnt_r, div_cnt_nxt;
    logic [8:0] div_ratio;
    logic       fosc_nxt, fosc_r;
    logic       fcy_ph_r, fcy_ph_nxt;
    logic       fcy_nxt, fcy_r;
    always_comb begin
        case (ocs_pkg::ocs_src_t'(src_r))
            ocs_pkg::SRC_RC_D16:  div_ratio = 9'(ocs_pkg::RC_D16);
            ocs_pkg::SRC_RC_DIVN: div_ratio = rc_ratio(rcdiv_r);
            default:              div_ratio = 9'h001;
        endcase
        div_cnt_nxt = div_cnt_r;
        fosc_nxt    = 1'b0;
        fcy_ph_nxt  = fcy_ph_r;
        fcy_nxt     = 1'b0;
        if (st_r == ocs_pkg::ST_RUN && src_rise) begin
            if (div_cnt_r >= div_ratio - 9'h001) begin
                div_cnt_nxt = 9'h000;
                fosc_nxt    = 1'b1;
                fcy_ph_nxt  = ~fcy_ph_r;
                fcy_nxt     = fcy_ph_r;
            end else begin
                div_cnt_nxt = div_cnt_r + 9'h001;
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            div_cnt_r <= 9'h000;
            fosc_r    <= 1'b0;
            fcy_ph_r  <= 1'b0;
            fcy_r     <= 1'b0;
        end else begin
            div_cnt_r <= div_cnt_nxt;
            fosc_r    <= fosc_nxt;
            fcy_ph_r  <= fcy_ph_nxt;
            fcy_r     <= fcy_nxt;
        end
    end

    // Analog PLL settings and routing, all from flops
    logic        pin_r;
    logic        ref_r;
    logic        act_r;
    logic [1:0]  drv_r;
    logic [5:0]  pre_fac_r;
    logic [3:0]  post_fac_r;
    logic [9:0]  m_r;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pin_r <= 1'b0;
            ref_r <= 1'b0;
            act_r <= 1'b0;
            drv_r <= ocs_pkg::PM_OFF;
            pre_fac_r  <= 6'h02;
            post_fac_r <= 4'h4;
            m_r        <= 10'h032;
        end else begin
            // PLL fed only from fast RC or primary
            pin_r <= (src_r == ocs_pkg::SRC_PRI_PLL) ? s2_r[2] : s2_r[0];
            ref_r <= rise[1];
            act_r <= (st_r == ocs_pkg::ST_RUN);
            // Primary mode used only for primary sources
            drv_r <= (src_r == ocs_pkg::SRC_PRI || src_r == ocs_pkg::SRC_PRI_PLL)
                     ? pmode_r : ocs_pkg::PM_OFF;
            pre_fac_r <= 6'(pre_r) + 6'h02;
            // Ten bits: the top code gives 513
            m_r   <= 10'(fbd_r) + 10'h002;
            // Reserved code 10 treated as divide by 4
            case (post_r)
                2'b00:   post_fac_r <= 4'h2;
                2'b11:   post_fac_r <= 4'h8;
                default: post_fac_r <= 4'h4;
            endcase
        end
    end
    assign fosc_tick        = fosc_r;
    assign fcy_tick         = fcy_r;
    assign sys_clk_active   = act_r;
    assign pll_input_clock  = pin_r;
    assign ref_clock_tick   = ref_r;
    assign rc_tune          = tune_r;
    assign multiplier       = m_r;
    assign prescale_factor  = pre_fac_r;
    assign postscale_factor = post_fac_r;
    assign primary_drive    = drv_r;
endmodule : ocs_clock_select

// ===== src/ocs_pkg.sv
// Purpose: Constants for the oscillator and clock select block
// Assumes: APB slave on core_clk, 32-bit data, one word per register
// Notes:   Offsets, DIV fields, register reset values and state/source/mode encodings live here
package ocs_pkg;
    // Register byte offsets
    localparam logic [7:0] CFG_OFF    = 8'h00;
    localparam logic [7:0] DIV_OFF    = 8'h04;
    localparam logic [7:0] FBD_OFF    = 8'h08;
    localparam logic [7:0] TUNE_OFF   = 8'h0C;
    localparam logic [7:0] STAT_OFF   = 8'h10;
    localparam logic [7:0] AUX_OFF    = 8'h14;
    // Divider control fields
    localparam int RCDIV_LSB  = 8;
    localparam int POST_LSB   = 6;
    localparam int PRE_LSB    = 0;
    // Reset values
    localparam logic [2:0] RCDIV_RST  = 3'h0;
    localparam logic [1:0] POST_RST   = 2'h1;
    localparam logic [4:0] PRE_RST    = 5'h00;
    localparam logic [8:0] FBD_RST    = 9'h030;
    localparam logic [5:0] TUNE_RST   = 6'h00;
    localparam logic [1:0] AUX_RST    = 2'h0;
    // Erased configuration: RC with programmable divide
    localparam logic [2:0] SRC_ERASED = 3'h7;
    localparam logic [1:0] MODE_ERASED = 2'h3;
    // Source codes
    typedef enum logic [2:0] {
        SRC_RC      = 3'b000,
        SRC_RC_PLL  = 3'b001,
        SRC_PRI     = 3'b010,
        SRC_PRI_PLL = 3'b011,
        SRC_SEC     = 3'b100,
        SRC_LOWRC   = 3'b101,
        SRC_RC_D16  = 3'b110,
        SRC_RC_DIVN = 3'b111
    } ocs_src_t;
    // Primary modes
    typedef enum logic [1:0] {
        PM_EXT  = 2'b00,
        PM_XTAL = 2'b01,
        PM_HSX  = 2'b10,
        PM_OFF  = 2'b11
    } ocs_pmode_t;
    // Start-up sequence states
    typedef enum logic [1:0] {
        ST_LOAD = 2'b00,
        ST_WAIT = 2'b01,
        ST_RUN  = 2'b10
    } ocs_state_t;
    // Timing figures
    localparam int CLK_HZ          = 40_000_000;
    localparam int STARTUP_US      = 10;
    localparam int STARTUP_CYC     = STARTUP_US * (CLK_HZ / 1_000_000);
    localparam int RC_D16          = 16;
    localparam int FCY_DIV         = 2;
endpackage : ocs_pkg

// ===== verification/ocs_asserts.sv
// Purpose: Port-level checks of the clock select block
// Assumes: One core_clk domain, synchronous active-high reset
// Notes:   Output updates may lag a register write by one cycle
module ocs_asserts (
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        fosc_tick,
    input wire logic        fcy_tick,
    input wire logic        sys_clk_active,
    input wire logic        ref_clock_tick,
    input wire logic        low_power_internal_rc,
    input wire logic [5:0]  rc_tune,
    input wire logic [9:0]  multiplier,
    input wire logic [5:0]  prescale_factor,
    input wire logic [3:0]  postscale_factor,
    input wire logic [1:0]  primary_drive
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic [2:0] fcnt_r;
    logic [2:0] fcnt_nxt;
    logic       acc;
    function automatic logic [3:0] post_div(input logic [1:0] c);
        return c == 2'h0 ? 4'h2 : (c == 2'h3 ? 4'h8 : 4'h4);
    endfunction : post_div
    // Fosc ticks since the last fcy tick
    always_comb begin
        fcnt_nxt = fcy_tick ? 3'h0 : fcnt_r + {2'h0, fosc_tick};
    end
    always_ff @(posedge core_clk) begin
        fcnt_r <= sys_rst ? 3'h0 : fcnt_nxt;
    end
    assign acc = psel && penable && pready;
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; penable && !pready ##1 penable && pready; endsequence
    AST_APB_WAIT: assert property (s_setup |=> s_access)
        else $error("apb wait state wrong");
    AST_UNMAPPED: assert property (acc |-> pslverr == (paddr > ocs_pkg::AUX_OFF))
        else $error("slave error flag wrong");
    AST_RST_VALUES: assert property (disable iff (1'b0) sys_rst |=> multiplier == 10'h032
        && prescale_factor == 6'h02 && postscale_factor == 4'h4 && primary_drive == 2'h3 && !sys_clk_active)
        else $error("reset values wrong");
    AST_FBD_WR: assert property (acc && pwrite && paddr == ocs_pkg::FBD_OFF |-> ##2
        multiplier == {1'b0, $past(pwdata[8:0], 2)} + 10'h002)
        else $error("multiplier not code plus two");
    AST_DIV_WR: assert property (acc && pwrite && paddr == ocs_pkg::DIV_OFF |-> ##2
        prescale_factor == {1'b0, $past(pwdata[4:0], 2)} + 6'h02
        && postscale_factor == post_div($past(pwdata[7:6], 2)))
        else $error("divider factors wrong");
    AST_TUNE_WR: assert property (acc && pwrite && paddr == ocs_pkg::TUNE_OFF |-> ##2
        rc_tune == $past(pwdata[5:0], 2))
        else $error("tuning value wrong");
    AST_FCY_HALF: assert property (fcy_tick |-> fcnt_r + {2'h0, fosc_tick} == 3'h2)
        else $error("fcy not every second fosc");
    AST_TICK_RUN: assert property (fosc_tick || fcy_tick |-> sys_clk_active)
        else $error("tick while clock inactive");
    AST_ACTIVE_HOLD: assert property (sys_clk_active |=> sys_clk_active)
        else $error("clock dropped without reset");
    AST_REF_EDGE: assert property ($rose(low_power_internal_rc) |-> ##[1:5] ref_clock_tick)
        else $error("reference tick missing");
endmodule : ocs_asserts
bind ocs_clock_select ocs_asserts u_chk (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .fosc_tick, .fcy_tick, .sys_clk_active, .ref_clock_tick, .low_power_internal_rc,
    .rc_tune, .multiplier, .prescale_factor, .postscale_factor, .primary_drive);

// ===== verification/ocs_osc_model.sv
// Purpose: Oscillator sources and analog PLL stand-in
// Assumes: Every source is slower than half of core_clk
// Notes:   Lock comes LOCK_NS after reset release; sources run free
module ocs_osc_model #(
    parameter int RC_NS   = 110,
    parameter int LOWRC_NS = 400,
    parameter int PRI_NS  = 150,
    parameter int SEC_NS  = 300,
    parameter int PLL_NS  = 60,
    parameter int LOCK_NS = 3000
) (
    input  wire logic sys_rst,
    output logic      rc_clk,
    output logic      lowrc_clk,
    output logic      pri_clk,
    output logic      sec_clk,
    output logic      pll_clk,
    output logic      aux_clk,
    output logic      locked
);
    timeunit 1ns;
    timeprecision 1ps;
    // Start low; periods unrelated to core_clk
    initial begin
        rc_clk = 1'b0;
        lowrc_clk = 1'b0;
        pri_clk = 1'b0;
        sec_clk = 1'b0;
        pll_clk = 1'b0;
        aux_clk = 1'b0;
    end
    // Crystals and RC sources never stop
    always #(RC_NS / 2.0) rc_clk = ~rc_clk;
    always #(LOWRC_NS / 2.0) lowrc_clk = ~lowrc_clk;
    always #(PRI_NS / 2.0) pri_clk = ~pri_clk;
    always #(SEC_NS / 2.0) sec_clk = ~sec_clk;
    always #(PLL_NS / 2.0) pll_clk = ~pll_clk;
    always #155 aux_clk = ~aux_clk;
    // Lock lost in reset, regained after a settling time
    // Polled, so a short reset during settling is never missed
    realtime rel_t = 0.0;
    always @(negedge sys_rst) rel_t = $realtime;
    always #1 locked = !sys_rst && ($realtime - rel_t >= LOCK_NS);
endmodule : ocs_osc_model

// ===== verification/tb_top.sv
// Purpose: Self-checking bench of the clock select block
// Assumes: Sources from the partner model, APB master in tasks
// Notes:   Tick counts allow two ticks of phase slack
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        config_erased = 1'b0;
    logic [2:0]  initial_source_select = 3'h7;
    logic [1:0]  primary_mode_select = 2'h3;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic        rc, lowrc, pri, sec, pll, aux, lock, e, pready, pslverr, fosc_tick, fcy_tick;
    logic        sys_clk_active, pll_input_clock, ref_clock_tick;
    logic [5:0]  rc_tune, prescale_factor;
    logic [9:0]  multiplier;
    logic [3:0]  postscale_factor;
    logic [1:0]  primary_drive;
    logic [4:0]  pc [4] = '{5'h00, 5'h01, 5'h10, 5'h1F};
    logic [8:0]  fb [3] = '{9'h000, 9'h01E, 9'h1FF};
    int          pd [4] = '{2, 4, 4, 8};
    int          rd [8] = '{1, 2, 4, 8, 16, 32, 64, 256};
    int          per [8];
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          nf, ny, np, i;
    // 40 MHz core clock
    always #12.5 core_clk = ~core_clk;
    ocs_osc_model osc (.sys_rst, .rc_clk(rc), .lowrc_clk(lowrc), .pri_clk(pri), .sec_clk(sec),
        .pll_clk(pll), .aux_clk(aux), .locked(lock));
    ocs_clock_select dut (.core_clk, .sys_rst, .config_erased, .initial_source_select,
        .primary_mode_select, .fast_internal_rc(rc), .low_power_internal_rc(lowrc),
        .primary_osc_input(pri), .secondary_osc_input(sec), .pll_clock(pll), .pll_locked(lock),
        .auxiliary_oscillator(aux), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .fosc_tick, .fcy_tick, .sys_clk_active, .pll_input_clock, .ref_clock_tick,
        .rc_tune, .multiplier, .prescale_factor, .postscale_factor, .primary_drive);
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    function automatic logic near(input int a, input int b);
        return (a - b <= 2) && (b - a <= 2);
    endfunction : near
    // One transfer; idle cycle first so drivers never clash
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        // Ready, read data and error all taken at one rising edge
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            n_mismatch++;
            report_and_stop();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask : rdc
    // Power-on with new configuration fields
    task automatic boot(input logic [2:0] s, input logic [1:0] m, input logic er);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        initial_source_select <= s;
        primary_mode_select <= m;
        config_erased <= er;
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
    endtask : boot
    task automatic wait_active();
        int k;
        for (k = 0; k < 30000 && sys_clk_active !== 1'b1; k++) @(negedge core_clk);
        if (sys_clk_active !== 1'b1) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask : wait_active
    // Tick and edge counts over 50 us
    task automatic meas();
        logic pv;
        pv = pll_input_clock;
        nf = 0;
        ny = 0;
        np = 0;
        repeat (2000) begin
            @(negedge core_clk);
            nf += fosc_tick;
            ny += fcy_tick;
            np += pll_input_clock && !pv;
            pv = pll_input_clock;
        end
    endtask : meas
    initial begin
        per = '{osc.RC_NS, osc.RC_NS, osc.PRI_NS, osc.PRI_NS, osc.SEC_NS, osc.LOWRC_NS, 16 * osc.RC_NS, osc.RC_NS};
        // Every source code; PLL modes judged by the PLL input
        for (i = 0; i < 8; i++) begin
            boot(i[2:0], 2'h2, 1'b0);
            wait_active();
            rdc(ocs_pkg::CFG_OFF, {27'h0, 2'h2, i[2:0]});
            chk(32'(primary_drive), (i == 2 || i == 3) ? 32'h2 : 32'h3);
            meas();
            chk(32'(near((i == 1 || i == 3) ? np : nf, 50000 / per[i])), 32'h1);
            chk(32'(near(2 * ny, nf)), 32'h1);
        end
        // Primary sub-modes; LOAD takes one cycle after release
        for (i = 0; i < 3; i++) begin
            boot(3'h2, i[1:0], 1'b0);
            repeat (4) @(posedge core_clk);
            chk(32'(primary_drive), 32'(i));
        end
        boot(3'h2, 2'h2, 1'b1);
        wait_active();
        rdc(ocs_pkg::CFG_OFF, 32'h1F);
        rdc(ocs_pkg::DIV_OFF, 32'h40);
        rdc(ocs_pkg::FBD_OFF, 32'h30);
        rdc(ocs_pkg::TUNE_OFF, 32'h0);
        rdc(ocs_pkg::STAT_OFF, 32'h6);
        wr(ocs_pkg::CFG_OFF, 32'hFFFFFFFF);
        rdc(ocs_pkg::CFG_OFF, 32'h1F);
        wr(8'h18, 32'h1);
        chk(32'(e), 32'h1);
        rdc(8'h18, 32'h0);
        wr(ocs_pkg::TUNE_OFF, 32'hFFFFFFFF);
        rdc(ocs_pkg::TUNE_OFF, 32'h3F);
        chk(32'(rc_tune), 32'h3F);
        wr(ocs_pkg::AUX_OFF, 32'h3);
        rdc(ocs_pkg::AUX_OFF, 32'h3);
        // Prescale and postscale codes incl. reserved and end codes
        for (i = 0; i < 4; i++) begin
            wr(ocs_pkg::DIV_OFF, {24'h0, i[1:0], 1'b0, pc[i]});
            rdc(ocs_pkg::DIV_OFF, {24'h0, i[1:0], 1'b0, pc[i]});
            chk(32'(prescale_factor), 32'(pc[i]) + 32'h2);
            chk(32'(postscale_factor), 32'(pd[i]));
        end
        for (i = 0; i < 3; i++) begin
            wr(ocs_pkg::FBD_OFF, {23'h0, fb[i]});
            rdc(ocs_pkg::FBD_OFF, {23'h0, fb[i]});
            chk(32'(multiplier), 32'(fb[i]) + 32'h2);
        end
        // Legal ratio: 10 MHz in, 5 MHz to the VCO, 160 MHz VCO, 80 MHz out
        wr(ocs_pkg::DIV_OFF, 32'h0);
        wr(ocs_pkg::FBD_OFF, 32'h1E);
        // Multiplier follows the register one cycle later
        repeat (2) @(posedge core_clk);
        chk(32'(multiplier) / (32'(prescale_factor) * 32'(postscale_factor)), 32'h8);
        // RC postscaler, every code
        for (i = 0; i < 8; i++) begin
            wr(ocs_pkg::DIV_OFF, 32'(i) << 8);
            meas();
            chk(32'(near(nf, 50000 / (osc.RC_NS * rd[i]))), 32'h1);
        end
        report_and_stop();
    end
endmodule : tb_top
